// [rtl/dac_frame_pkg.sv]
// Purpose: constants shared by the serial frame front end
// Assumes: 100 MHz system clock, pins sampled through three flip-flops
// Notes: Constant and type list below
package dac_frame_pkg;
  localparam int CLK_MHZ = 100;
  localparam int FRAME_LEN_PLAIN = 24;
  localparam int FRAME_LEN_CRC = 32;
  localparam int WORD_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h18;
  localparam logic [CNT_W-1:0] LEN_CRC = 6'h20;
  localparam int PAD_PLAIN = FRAME_LEN_CRC - FRAME_LEN_PLAIN;
  // update latency limits from a strobe fall, ns
  localparam int UPD_NS_FAST = 600;
  localparam int UPD_NS_SLEW = 2000;
  localparam int UPD_CYC_FAST = UPD_NS_FAST * CLK_MHZ / 1000;
  localparam int UPD_CYC_SLEW = UPD_NS_SLEW * CLK_MHZ / 1000;
  localparam int SYNC_STAGES = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_FULL = 2'b11
  } frame_e;
endpackage

// [rtl/pin_if.sv]
// Purpose: synchronised pin levels and edges between front end modules
// Assumes: all members are in the clk domain
// Notes: edges are one-cycle pulses
`timescale 1ns/100ps
interface pin_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic sel_n;
  logic sdi;
  logic ld_fall;
  logic ld_n;
  modport src (output sclk_rise, sclk_fall, sel_fall, sel_rise, sel_n, sdi, ld_fall, ld_n);
  modport snk (input sclk_rise, sclk_fall, sel_fall, sel_rise, sel_n, sdi, ld_fall, ld_n);
endinterface

// [rtl/pin_sync.sv]
// Purpose: bring the four serial pins into the clk domain
// Assumes: pins change slower than a few clk periods
// Notes: edges look only at stages two and three
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic load_strobe_n,
  pin_if.src p
);
  localparam int N = 4;
  logic [N-1:0] raw;
  logic [N-1:0] s2;
  logic [N-1:0] s3;

  assign raw = {load_strobe_n, sdi, sync_n, sclk};

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic [dac_frame_pkg::SYNC_STAGES-1:0] sh_r;
      logic [dac_frame_pkg::SYNC_STAGES-1:0] sh_nxt;
      always_comb begin
        sh_nxt = {sh_r[dac_frame_pkg::SYNC_STAGES-2:0], raw[i]};
      end
      // idle levels: clock low, select and strobe high
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sh_r <= (i == 0 || i == 2) ? 3'h0 : 3'h7;
        end else begin
          sh_r <= sh_nxt;
        end
      end
      assign s2[i] = sh_r[1];
      assign s3[i] = sh_r[2];
    end
  endgenerate

  assign p.sclk_rise = s2[0] & ~s3[0];
  assign p.sclk_fall = ~s2[0] & s3[0];
  assign p.sel_fall = ~s2[1] & s3[1];
  assign p.sel_rise = s2[1] & ~s3[1];
  assign p.sel_n = s2[1];
  assign p.sdi = s2[2];
  assign p.ld_fall = ~s2[3] & s3[3];
  assign p.ld_n = s2[3];
endmodule

// [rtl/dac_frame.sv]
// Purpose: serial frame capture, readback shift and output update timing
// Assumes: host keeps all gap and strobe timing it is bound to
// Notes: sclk must stay under about a sixth of clk to be sampled
`timescale 1ns/100ps
module dac_frame (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic load_strobe_n,
  output logic sdo,
  output logic sdo_oe,
  input wire logic crc_en,
  input wire logic [31:0] rd_word,
  output logic [31:0] frame_word,
  output logic frame_valid,
  input wire logic code_write,
  output logic [31:0] out_word,
  output logic out_update
);
  pin_if p ();

  pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdi(sdi),
    .load_strobe_n(load_strobe_n),
    .p(p)
  );

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  dac_frame_pkg::frame_e st_r;
  dac_frame_pkg::frame_e st_nxt;
  logic [dac_frame_pkg::CNT_W-1:0] cnt_r;
  logic [dac_frame_pkg::CNT_W-1:0] cnt_nxt;
  logic [31:0] in_sh_r;
  logic [31:0] in_sh_nxt;
  logic [31:0] out_sh_r;
  logic [31:0] out_sh_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic fw_valid_r;
  logic fw_valid_nxt;
  logic [31:0] fw_r;
  logic [31:0] fw_nxt;
  logic [dac_frame_pkg::CNT_W-1:0] len;

  assign len = crc_en ? dac_frame_pkg::LEN_CRC : dac_frame_pkg::LEN_PLAIN;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    in_sh_nxt = in_sh_r;
    out_sh_nxt = out_sh_r;
    sdo_nxt = sdo_r;
    fw_valid_nxt = 1'b0;
    fw_nxt = fw_r;
    case (st_r)
      dac_frame_pkg::FR_IDLE: begin
        if (p.sel_fall) begin
          st_nxt = dac_frame_pkg::FR_SHIFT;
          cnt_nxt = '0;
          in_sh_nxt = '0;
          // 24-bit words sit at the top so zeros follow them out
          out_sh_nxt = crc_en ? rd_word
                              : {rd_word[23:0], {dac_frame_pkg::PAD_PLAIN{1'b0}}};
          sdo_nxt = out_sh_nxt[31];
        end
      end
      dac_frame_pkg::FR_SHIFT, dac_frame_pkg::FR_FULL: begin
        if (p.sel_rise) begin
          st_nxt = dac_frame_pkg::FR_IDLE;
          // short frames drop here without a trace
          if (st_r == dac_frame_pkg::FR_FULL) begin
            fw_valid_nxt = 1'b1;
            fw_nxt = crc_en ? in_sh_r : {8'h00, in_sh_r[23:0]};
          end
        end else begin
          if (p.sclk_fall) begin
            if (cnt_r != dac_frame_pkg::CNT_MAX) begin
              cnt_nxt = cnt_r + 6'h01;
            end
            // bits past the frame length are not captured
            if (st_r == dac_frame_pkg::FR_SHIFT) begin
              in_sh_nxt = {in_sh_r[30:0], p.sdi};
            end
            if (cnt_nxt >= len) begin
              st_nxt = dac_frame_pkg::FR_FULL;
            end
          end
          // shift only after the host has captured the current bit
          if (p.sclk_rise && cnt_r != '0) begin
            out_sh_nxt = {out_sh_r[30:0], 1'b0};
            sdo_nxt = out_sh_r[30];
          end
        end
      end
      default: begin
        st_nxt = dac_frame_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= dac_frame_pkg::FR_IDLE;
      cnt_r <= '0;
      in_sh_r <= dac_frame_pkg::WORD_RST;
      out_sh_r <= dac_frame_pkg::WORD_RST;
      sdo_r <= 1'b0;
      fw_valid_r <= 1'b0;
      fw_r <= dac_frame_pkg::WORD_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      in_sh_r <= in_sh_nxt;
      out_sh_r <= out_sh_nxt;
      sdo_r <= sdo_nxt;
      fw_valid_r <= fw_valid_nxt;
      fw_r <= fw_nxt;
    end
  end

  assign sdo = sdo_r;
  assign sdo_oe = ~p.sel_n;
  assign frame_word = fw_r;
  assign frame_valid = fw_valid_r;

  // ---------------------------------------------------------------
  // output update
  // ---------------------------------------------------------------
  logic pend_r;
  logic pend_nxt;
  logic [31:0] held_r;
  logic [31:0] held_nxt;
  logic [31:0] ow_r;
  logic [31:0] ow_nxt;
  logic upd_r;
  logic upd_nxt;

  always_comb begin
    pend_nxt = pend_r;
    held_nxt = held_r;
    ow_nxt = ow_r;
    upd_nxt = 1'b0;
    if (p.ld_fall && pend_r) begin
      ow_nxt = held_r;
      upd_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
    if (fw_valid_r && code_write) begin
      if (!p.ld_n) begin
        ow_nxt = fw_r;
        upd_nxt = 1'b1;
        pend_nxt = 1'b0;
      end else begin
        held_nxt = fw_r;
        pend_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
      held_r <= dac_frame_pkg::WORD_RST;
      ow_r <= dac_frame_pkg::WORD_RST;
      upd_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      held_r <= held_nxt;
      ow_r <= ow_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign out_word = ow_r;
  assign out_update = upd_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  frame_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(fw_valid_r) |-> $past(cnt_r) >= $past(len))
    else $error("frame accepted with too few clock edges");

  extra_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_r != dac_frame_pkg::FR_IDLE && cnt_r > len) |-> sdo_r == 1'b0)
    else $error("serial output not zero after frame length");

  sdo_launch_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(sdo_r) |-> $past(p.sclk_rise) || $past(p.sel_fall))
    else $error("serial output changed off a rising clock edge");

  short_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    (p.sel_rise && st_r == dac_frame_pkg::FR_SHIFT) |=> !fw_valid_r)
    else $error("short frame was not discarded");

  strobe_update_a: assert property (@(posedge clk) disable iff (!reset_n)
    (p.ld_fall && pend_r && !(fw_valid_r && code_write)) |=> upd_r && ow_r == $past(held_r))
    else $error("strobe fall did not update the output");

  direct_update_a: assert property (@(posedge clk) disable iff (!reset_n)
    (fw_valid_r && code_write && !p.ld_n) |=> upd_r && ow_r == $past(fw_r))
    else $error("code write with strobe low did not update");

  hold_pend_a: assert property (@(posedge clk) disable iff (!reset_n)
    (fw_valid_r && code_write && p.ld_n) |=> pend_r && !upd_r)
    else $error("code write with strobe high did not wait");
endmodule

// [sim/spi_host_model.sv]
// Purpose: host side of the serial frame link
// Assumes: sclk idles low, each sclk phase lasts HALF clk periods
// Notes: outputs are set by blocking assignment at time zero, then change only by non-blocking assignment at clk rise
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  output logic load_strobe_n
);
  localparam int HALF = 6;
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
    load_strobe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ------------------------------
  // one frame of n falls, len word bits
  // ------------------------------
  task automatic frame(input logic [31:0] w, input int len, input int n, input int gap,
                       output logic [63:0] rd);
    rd = '0;
    sync_n <= 1'b0;
    tick(HALF);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      sdi <= (i < len) ? w[len-1-i] : 1'b0;
      tick(HALF);
      rd = {rd[62:0], sdo};
      sclk <= 1'b0;
      tick(HALF);
    end
    sync_n <= 1'b1;
    // released data line must not keep its last value
    sdi <= ~sdi;
    tick(gap);
  endtask
  task automatic set_strobe(input logic lvl);
    load_strobe_n <= lvl;
    tick(1);
  endtask
endmodule

// [sim/dac_serial_frame_timing_tb_top.sv]
// Purpose: self-checking bench for the serial frame front end
// Assumes: host model keeps all gap and strobe timing
// Notes: bit 31 of a checksum frame marks an output code write
`timescale 1ns/100ps
module dac_serial_frame_timing_tb_top;
  logic clk, reset_n, crc_en, code_write, frame_valid, out_update;
  logic sclk, sync_n, sdi, load_strobe_n, sdo, sdo_oe;
  logic [31:0] rd_word, frame_word, out_word;
  logic [63:0] rd;
  int errors = 0;
  int num_checks = 0;
  int fv_cnt = 0;
  int up_cnt = 0;
  int b;
  int ob;
  int oe_cnt = 0;
  assign code_write = frame_valid & frame_word[31];
  spi_host_model host_u (.clk(clk), .sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
                         .load_strobe_n(load_strobe_n));
  dac_frame dut_u (.clk(clk), .reset_n(reset_n), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
                   .load_strobe_n(load_strobe_n), .sdo(sdo), .sdo_oe(sdo_oe), .crc_en(crc_en),
                   .rd_word(rd_word), .frame_word(frame_word), .frame_valid(frame_valid),
                   .code_write(code_write), .out_word(out_word), .out_update(out_update));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (frame_valid === 1'b1) fv_cnt <= fv_cnt + 1;
    if (out_update === 1'b1) up_cnt <= up_cnt + 1;
    if (sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end
  // ------------------------------
  // checking and reporting
  // ------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_up(input int base, input int lim);
    for (int k = 0; k < lim && up_cnt == base; k++) @(posedge clk);
    if (up_cnt == base) begin
      errors++;
      $display("Error out_update expected pulse seen none");
      close_out();
    end
  endtask
  task automatic setup(input logic crc, input logic [31:0] rw);
    crc_en <= crc;
    rd_word <= rw;
    @(posedge clk);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_plain();
    setup(1'b0, 32'ha5c3_0f96);
    b = fv_cnt;
    ob = oe_cnt;
    host_u.frame(32'h00ab_cdef, 24, 24, 50, rd);
    chk("frame_valid", 1, fv_cnt - b);
    chk("frame_word", 32'h00ab_cdef, frame_word);
    chk("sdo", 64'h00c3_0f96, rd);
    // select is low for 6 + 12 * 24 clk periods of the host model
    chk("sdo_oe", 294, oe_cnt - ob);
    chk("sdo_oe", 0, sdo_oe);
    $display("test plain done");
  endtask
  task automatic t_extra();
    setup(1'b1, 32'h8123_4567);
    b = fv_cnt;
    host_u.frame(32'h1234_5678, 32, 34, 50, rd);
    chk("frame_valid", 1, fv_cnt - b);
    chk("frame_word", 32'h1234_5678, frame_word);
    chk("sdo", 64'h2_048d_159c, rd);
    $display("test extra done");
  endtask
  task automatic t_short();
    setup(1'b0, 32'h0000_0000);
    b = fv_cnt;
    host_u.frame(32'h00ff_ffff, 24, 20, 50, rd);
    chk("frame_valid", 0, fv_cnt - b);
    chk("frame_word", 32'h1234_5678, frame_word);
    $display("test short done");
  endtask
  task automatic t_strobe();
    setup(1'b1, 32'h0000_0000);
    b = up_cnt;
    host_u.frame(32'h8000_1234, 32, 32, 150, rd);
    chk("out_update", 0, up_cnt - b);
    host_u.set_strobe(1'b0);
    wait_up(b, dac_frame_pkg::UPD_CYC_FAST);
    chk("out_word", 32'h8000_1234, out_word);
    repeat (25) @(posedge clk);
    host_u.set_strobe(1'b1);
    $display("test strobe done");
  endtask
  task automatic t_held();
    host_u.set_strobe(1'b0);
    repeat (150) @(posedge clk);
    b = up_cnt;
    host_u.frame(32'h8000_beef, 32, 32, 0, rd);
    wait_up(b, 150);
    chk("out_word", 32'h8000_beef, out_word);
    repeat (150) @(posedge clk);
    host_u.set_strobe(1'b1);
    $display("test held done");
  endtask
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (500) @(posedge clk);
    chk("frame_word", 32'h0000_0000, frame_word);
    chk("out_word", 32'h0000_0000, out_word);
    chk("sdo", 0, sdo);
    chk("sdo_oe", 0, sdo_oe);
    reset_n <= 1'b1;
    repeat (10000) @(posedge clk);
    chk("out_word", 32'h0000_0000, out_word);
    $display("test reset done");
  endtask
  task automatic t_range();
    setup(1'b1, 32'h0000_0000);
    b = fv_cnt;
    ob = up_cnt;
    // setup write that changes the range: long select high gap follows
    host_u.frame(32'h4c00_0005, 32, 32, 50000, rd);
    chk("frame_valid", 1, fv_cnt - b);
    chk("frame_word", 32'h4c00_0005, frame_word);
    chk("out_update", 0, up_cnt - ob);
    host_u.set_strobe(1'b0);
    repeat (30) @(posedge clk);
    host_u.set_strobe(1'b1);
    // nothing pending, so the strobe pulse must not update
    chk("out_update", 0, up_cnt - ob);
    $display("test range done");
  endtask
  initial begin
    reset_n = 1'b0;
    crc_en = 1'b0;
    rd_word = 32'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_plain();
    t_extra();
    t_short();
    t_strobe();
    t_held();
    t_reset();
    t_range();
    close_out();
  end
endmodule
